/* File: soje_pkg.sv */
// Shared constants, types and helpers of the single-operand and jump execution core
package soje_pkg;
  // Status register layout: flag positions chosen so masks 1, 2 and 4 hit C, Z, N
  localparam int SR_C      = 0; // RULE21
  localparam int SR_Z      = 1; // RULE21
  localparam int SR_N      = 2; // RULE21
  localparam int SR_IRQ_EN = 3; // RULE19
  localparam int SR_HALT   = 4; // RULE18
  localparam int SR_NO_OSC = 5; // RULE17
  localparam int SR_V      = 8;
  localparam logic [15:0] SR_MASK   = 16'h01FF;
  localparam logic [15:0] RESET_PC  = 16'h0000;
  localparam logic [15:0] RESET_SP  = 16'h0000;
  localparam logic [15:0] RESET_SR  = 16'h0000;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [15:0] STEP_BYTE = 16'h0001;

  localparam logic [3:0] REG_PC = 4'h0;
  localparam logic [3:0] REG_SP = 4'h1;
  localparam logic [3:0] REG_SR = 4'h2;
  localparam logic [3:0] REG_CG = 4'h3;

  localparam logic [5:0] FMT2_CODE = 6'h04;
  localparam logic [2:0] JUMP_CODE = 3'h1;
  localparam logic [1:0] AM_REG    = 2'h0;
  localparam logic [1:0] AM_IDX    = 2'h1;
  localparam logic [1:0] AM_IND    = 2'h2;
  localparam logic [1:0] AM_INC    = 2'h3;

  localparam logic [1:0] BE_WORD = 2'h3;
  localparam logic [1:0] BE_LO   = 2'h1;
  localparam logic [1:0] BE_HI   = 2'h2;

  // APB register map
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_STAT  = 8'h04;
  localparam logic [7:0] A_PC    = 8'h08;
  localparam logic [7:0] A_SP    = 8'h0C;
  localparam logic [7:0] A_SR    = 8'h10;
  localparam logic [7:0] A_SRSET = 8'h14;
  localparam logic [7:0] A_SRCLR = 8'h18;
  localparam logic [7:0] A_INSN  = 8'h1C;
  localparam int CTRL_RUN   = 0;
  localparam int STAT_UNSUP = 2;

  typedef enum logic [2:0] {
    OP_RRC = 3'h0, OP_BSWAP = 3'h1, OP_RRA = 3'h2, OP_SEXT = 3'h3,
    OP_PUSH = 3'h4, OP_CALL = 3'h5, OP_INTERRUPT_RETURN = 3'h6, OP_NONE = 3'h7
  } soje_op_t;

  typedef enum logic [2:0] {
    CC_NE = 3'h0, CC_EQ = 3'h1, CC_NC = 3'h2, CC_C = 3'h3,
    CC_N = 3'h4, CC_GE = 3'h5, CC_L = 3'h6, CC_ALWAYS = 3'h7
  } soje_cond_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_FETCH = 4'h1, S_DECODE = 4'h2, S_EXT = 4'h3, S_OPRD = 4'h4,
    S_EXEC = 4'h5, S_WRB = 4'h6, S_INTERRUPT_RETURN_SR = 4'h7, S_INTERRUPT_RETURN_PC = 4'h8
  } soje_state_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [1:0]  be;
    logic [15:0] addr;
    logic [15:0] wdata;
  } soje_mem_t;

  typedef struct packed {
    logic [15:0] value;
    logic        v;
    logic        n;
    logic        z;
    logic        c;
    logic        upd;
  } soje_alu_t;

  function automatic soje_mem_t mem_rd(input logic [15:0] a);
    return '{req: 1'h1, we: 1'h0, be: BE_WORD, addr: a, wdata: 16'h0000};
  endfunction

  function automatic soje_mem_t mem_wr(input logic [15:0] a, input logic [15:0] d, input logic [1:0] be);
    return '{req: 1'h1, we: 1'h1, be: be, addr: a, wdata: d};
  endfunction

  // Signed 10-bit word offset doubled into a byte displacement
  function automatic logic [15:0] jump_offset(input logic [9:0] f);
    return {{5{f[9]}}, f, 1'h0}; // RULE7
  endfunction

  function automatic logic jump_taken(input soje_cond_t cc, input logic [15:0] s);
    logic t;
    t = 1'h0;
    unique case (cc)
      CC_NE:     t = !s[SR_Z]; // RULE10
      CC_EQ:     t = s[SR_Z]; // RULE10
      CC_NC:     t = !s[SR_C]; // RULE11
      CC_C:      t = s[SR_C]; // RULE11
      CC_N:      t = s[SR_N]; // RULE12
      CC_GE:     t = !(s[SR_N] ^ s[SR_V]); // RULE13
      CC_L:      t = s[SR_N] ^ s[SR_V]; // RULE13
      CC_ALWAYS: t = 1'h1; // RULE14
    endcase
    return t;
  endfunction
endpackage

/* File: soje_regs.sv */
// General register file with registered read port
`timescale 1ns/1ps
module soje_regs (
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  waddr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic [3:0]  raddr_i,
  output logic      [15:0] rdata_o
);
  logic [15:0] mem [16];

  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // Read returns the old word when read and write hit one entry in the same cycle
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule

/* File: soje_alu.sv */
// Shift, swap and sign-extend unit for single-operand instructions
`timescale 1ns/1ps
module soje_alu (
  input  wire logic                 bw_i,
  input  wire soje_pkg::soje_op_t   op_i,
  input  wire logic [15:0]          opnd_i,
  input  wire logic                 cin_i,
  output soje_pkg::soje_alu_t       res_o
);
  import soje_pkg::*;
  logic byte_op;
  logic msb_in;

  // Byte form exists only for the two shifts
  assign byte_op = bw_i && (op_i == OP_RRC || op_i == OP_RRA);
  assign msb_in  = byte_op ? opnd_i[7] : opnd_i[15];

  always_comb begin
    res_o = '0;
    unique case (op_i)
      OP_RRC: begin
        res_o.value = byte_op ? {8'h00, cin_i, opnd_i[7:1]} : {cin_i, opnd_i[15:1]}; // RULE1
        res_o.c     = opnd_i[0]; // RULE1
        res_o.v     = !msb_in && cin_i;
        res_o.upd   = 1'h1;
      end
      OP_RRA: begin
        res_o.value = byte_op ? {8'h00, opnd_i[7], opnd_i[7:1]} : {opnd_i[15], opnd_i[15:1]}; // RULE1
        res_o.c     = opnd_i[0]; // RULE1
        res_o.v     = 1'h0; // RULE1
        res_o.upd   = 1'h1;
      end
      OP_BSWAP: begin
        res_o.value = {opnd_i[7:0], opnd_i[15:8]}; // RULE20
        res_o.upd   = 1'h0; // RULE20
      end
      OP_SEXT: begin
        res_o.value = {{8{opnd_i[7]}}, opnd_i[7:0]}; // RULE3
        res_o.c     = |opnd_i[7:0]; // RULE3
        res_o.v     = 1'h0; // RULE3
        res_o.upd   = 1'h1;
      end
      default: begin
        res_o.value = opnd_i;
        res_o.upd   = 1'h0;
      end
    endcase
    res_o.n = byte_op ? res_o.value[7] : res_o.value[15];
    res_o.z = byte_op ? (res_o.value[7:0] == 8'h00) : (res_o.value == 16'h0000);
  end
endmodule

/* File: soje_core.sv */
// Execution core for single-operand and jump instructions with APB control port
//
// Functional notes
// [RULE1] Right shifts: carry or MSB in, LSB out
// [RULE2] Push: SP minus two, store source, flags kept
// [RULE3] Sign extend bit 7 upward, V cleared
// [RULE4] Call: push return address, load target into PC
// [RULE5] Interrupt return pops status then PC
// [RULE6] Call accepts all modes, extension word fetched
// [RULE7] Jump offset is signed ten bits, doubled
// [RULE8] Taken jump: PC plus two plus offset
// [RULE9] Jumps never change any status flag
// [RULE10] Equal on zero set, not-equal on clear
// [RULE11] Carry jump on set, no-carry on clear
// [RULE12] Negative jump only when N set
// [RULE13] Signed compare jumps on N xor V
// [RULE14] Unconditional jump always branches
// [RULE15] No emulated opcodes; basic encodings only
// [RULE16] Power control only through status register bits
// [RULE17] Mask 28h: oscillator off plus interrupts
// [RULE18] Mask 18h: CPU halt plus interrupts
// [RULE19] Interrupt enable is status bit value 8
// [RULE20] Byte swap exchanges bytes, flags kept
// [RULE21] C, Z, N at bits 0, 1, 2
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module soje_core (
  input  wire logic                 clk_sys_i,
  input  wire logic                 nrst_i,
  input  wire logic [7:0]           paddr_i,
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [31:0]          pwdata_i,
  output logic      [31:0]          prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  output soje_pkg::soje_mem_t       mem_o,
  input  wire logic                 mem_ack_i,
  input  wire logic [15:0]          mem_rdata_i,
  output logic                      cpu_halted_o,
  output logic                      osc_off_o,
  output logic                      irq_en_o
);
  import soje_pkg::*;

  soje_state_t state;
  soje_state_t next_state;
  soje_mem_t   mem;
  soje_mem_t   next_mem;
  soje_alu_t   alu;
  soje_op_t    op;
  soje_cond_t  cc;
  logic [15:0] pc;
  logic [15:0] sp;
  logic [15:0] sr;
  logic [15:0] insn;
  logic [15:0] opnd;
  logic [15:0] ea;
  logic [15:0] next_pc;
  logic [15:0] next_sp;
  logic [15:0] next_sr;
  logic [15:0] next_insn;
  logic [15:0] next_opnd;
  logic [15:0] next_ea;
  logic [15:0] rf_rdata;
  logic [15:0] rn;
  logic [15:0] step;
  logic [15:0] jmp_ofs;
  logic [15:0] ext_base;
  logic [15:0] mem_opnd;
  logic [15:0] wr_val;
  logic [15:0] wb_data;
  logic [31:0] rd_val;
  logic [31:0] stat_word;
  logic [3:0]  rf_raddr;
  logic [3:0]  rsel;
  logic [1:0]  am;
  logic [1:0]  wr_be;
  logic        is_fmt2;
  logic        is_jump;
  logic        bw;
  logic        needs_ext;
  logic        jmp_take;
  logic        mem_done;
  logic        wr_reg;
  logic        rf_we;
  logic        set_unsup;
  logic        run;
  logic        unsup;
  logic        next_run;
  logic        next_unsup;
  logic        can_load;
  logic        apb_setup;
  logic        apb_wr;
  logic        rd_hit;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        wr_pc;
  logic        wr_sp;
  logic        wr_sr;
  logic        wr_srset;
  logic        wr_srclr;
  logic        sr_sw;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;

  // Instruction field decode
  assign is_fmt2 = (insn[15:10] == FMT2_CODE);
  assign is_jump = (insn[15:13] == JUMP_CODE);
  assign op      = is_fmt2 ? soje_op_t'(insn[9:7]) : OP_NONE; // RULE15
  assign cc      = soje_cond_t'(insn[12:10]);
  assign bw      = insn[6];
  assign am      = insn[5:4];
  assign rsel    = insn[3:0];
  assign rn      = (rsel == REG_PC) ? pc :
                   (rsel == REG_SP) ? sp :
                   (rsel == REG_SR) ? sr :
                   (rsel == REG_CG) ? 16'h0000 : rf_rdata;
  assign step      = (bw && rsel != REG_SP) ? STEP_BYTE : STEP_WORD;
  assign needs_ext = (am == AM_IDX) || (am == AM_INC && rsel == REG_PC); // RULE6
  assign ext_base  = (rsel == REG_SR) ? 16'h0000 : rn; // RULE6
  assign jmp_ofs   = jump_offset(insn[9:0]); // RULE7
  assign jmp_take  = jump_taken(cc, sr);
  assign mem_done  = mem.req && mem_ack_i;
  assign mem_opnd  = !bw ? mem_rdata_i : (ea[0] ? {8'h00, mem_rdata_i[15:8]} : {8'h00, mem_rdata_i[7:0]});
  assign wr_be     = !bw ? BE_WORD : (ea[0] ? BE_HI : BE_LO);
  assign wb_data   = bw ? {2{alu.value[7:0]}} : alu.value;
  // Register file read address runs one step ahead so the operand is ready in decode
  assign rf_raddr  = (state == S_FETCH) ? mem_rdata_i[3:0] : rsel;
  assign rf_we     = wr_reg && (rsel > REG_CG);

  // APB decode
  assign apb_setup = psel_i && !penable_i;
  assign apb_wr    = psel_i && penable_i && pready && pwrite_i;
  assign wr_ctrl   = apb_wr && (paddr_i == A_CTRL);
  assign wr_stat   = apb_wr && (paddr_i == A_STAT);
  assign wr_pc     = apb_wr && (paddr_i == A_PC);
  assign wr_sp     = apb_wr && (paddr_i == A_SP);
  assign wr_sr     = apb_wr && (paddr_i == A_SR);
  assign wr_srset  = apb_wr && (paddr_i == A_SRSET);
  assign wr_srclr  = apb_wr && (paddr_i == A_SRCLR);
  assign sr_sw     = wr_sr || wr_srset || wr_srclr;
  assign can_load  = !run && (state == S_IDLE);
  assign stat_word = {20'h00000, state, 5'h00, unsup, (state == S_IDLE), sr[SR_HALT]};
  assign rd_hit    = (paddr_i == A_CTRL) || (paddr_i == A_STAT) || (paddr_i == A_PC) || (paddr_i == A_SP) ||
                     (paddr_i == A_SR) || (paddr_i == A_SRSET) || (paddr_i == A_SRCLR) || (paddr_i == A_INSN);
  assign rd_val    = (paddr_i == A_CTRL) ? {31'h00000000, run} :
                     (paddr_i == A_STAT) ? stat_word :
                     (paddr_i == A_PC)   ? {16'h0000, pc} :
                     (paddr_i == A_SP)   ? {16'h0000, sp} :
                     (paddr_i == A_SR)   ? {16'h0000, sr} :
                     (paddr_i == A_INSN) ? {16'h0000, insn} : 32'h00000000;
  assign next_run   = wr_ctrl ? pwdata_i[CTRL_RUN] : run;
  // A new unsupported word wins over a software clear in the same cycle
  assign next_unsup = set_unsup || (unsup && !(wr_stat && pwdata_i[STAT_UNSUP]));

  soje_regs u_regs (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .we_i      (rf_we),
    .waddr_i   (rsel),
    .wdata_i   (wr_val),
    .raddr_i   (rf_raddr),
    .rdata_o   (rf_rdata)
  );

  soje_alu u_alu (
    .bw_i   (bw),
    .op_i   (op),
    .opnd_i (opnd),
    .cin_i  (sr[SR_C]),
    .res_o  (alu)
  );

  always_comb begin
    next_state = state;
    next_pc    = pc;
    next_sp    = sp;
    next_sr    = sr;
    next_insn  = insn;
    next_opnd  = opnd;
    next_ea    = ea;
    next_mem   = mem;
    set_unsup  = 1'h0;
    wr_reg     = 1'h0;
    wr_val     = 16'h0000;
    if (mem_done) begin
      next_mem.req = 1'h0;
    end
    unique case (state)
      S_IDLE: begin
        // Halt is checked only between instructions
        if (run && !sr[SR_HALT]) begin // RULE18
          next_mem   = mem_rd(pc);
          next_state = S_FETCH;
        end
      end
      S_FETCH: begin
        if (mem_done) begin
          next_insn  = mem_rdata_i;
          next_pc    = pc + STEP_WORD;
          next_state = S_DECODE;
        end
      end
      S_DECODE: begin
        next_state = S_IDLE;
        if (is_jump) begin // RULE9
          if (jmp_take) begin
            next_pc = pc + jmp_ofs; // RULE8
          end
        end else if (op == OP_INTERRUPT_RETURN) begin
          next_mem   = mem_rd(sp); // RULE5
          next_state = S_INTERRUPT_RETURN_SR;
        end else if (op == OP_NONE) begin
          set_unsup = 1'h1; // RULE15
        end else if (needs_ext) begin
          next_mem   = mem_rd(pc); // RULE6
          next_state = S_EXT;
        end else if (am == AM_REG) begin
          next_opnd  = bw ? {8'h00, rn[7:0]} : rn;
          next_state = S_EXEC;
        end else begin
          next_ea    = rn;
          next_mem   = mem_rd(rn);
          next_state = S_OPRD;
          if (am == AM_INC) begin
            wr_reg = 1'h1;
            wr_val = rn + step;
          end
        end
      end
      S_EXT: begin
        if (mem_done) begin
          next_pc = pc + STEP_WORD;
          if (am == AM_INC) begin
            next_opnd  = mem_rdata_i;
            next_state = S_EXEC;
          end else begin
            next_ea    = ext_base + mem_rdata_i; // RULE6
            next_mem   = mem_rd(ext_base + mem_rdata_i);
            next_state = S_OPRD;
          end
        end
      end
      S_OPRD: begin
        if (mem_done) begin
          next_opnd  = mem_opnd;
          next_state = S_EXEC;
        end
      end
      S_EXEC: begin
        next_state = S_IDLE;
        if (op == OP_PUSH) begin
          next_sp    = sp - STEP_WORD; // RULE2
          next_mem   = mem_wr(sp - STEP_WORD, opnd, BE_WORD); // RULE2
          next_state = S_WRB;
        end else if (op == OP_CALL) begin
          next_sp    = sp - STEP_WORD; // RULE4
          next_mem   = mem_wr(sp - STEP_WORD, pc, BE_WORD); // RULE4
          next_state = S_WRB;
        end else begin
          if (alu.upd) begin
            next_sr[SR_V] = alu.v; // RULE1
            next_sr[SR_N] = alu.n;
            next_sr[SR_Z] = alu.z;
            next_sr[SR_C] = alu.c;
          end
          if (am == AM_REG) begin
            wr_reg = 1'h1;
            wr_val = alu.value;
          end else begin
            next_mem   = mem_wr(ea, wb_data, wr_be);
            next_state = S_WRB;
          end
        end
      end
      S_WRB: begin
        if (mem_done) begin
          next_state = S_IDLE;
          if (op == OP_CALL) begin
            next_pc = opnd; // RULE4
          end
        end
      end
      S_INTERRUPT_RETURN_SR: begin
        if (mem_done) begin
          next_sr    = mem_rdata_i & SR_MASK; // RULE5
          next_sp    = sp + STEP_WORD; // RULE5
          next_mem   = mem_rd(sp + STEP_WORD);
          next_state = S_INTERRUPT_RETURN_PC;
        end
      end
      S_INTERRUPT_RETURN_PC: begin
        if (mem_done) begin
          next_pc    = mem_rdata_i; // RULE5
          next_sp    = sp + STEP_WORD; // RULE5
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
    if (wr_reg) begin
      if (rsel == REG_PC) begin
        next_pc = wr_val;
      end else if (rsel == REG_SP) begin
        next_sp = wr_val;
      end else if (rsel == REG_SR) begin
        next_sr = wr_val & SR_MASK;
      end
    end
    // Software bit set and clear ride on top of the core's own update
    if (wr_sr) begin
      next_sr = pwdata_i[15:0] & SR_MASK; // RULE16
    end
    if (wr_srset) begin
      next_sr = next_sr | (pwdata_i[15:0] & SR_MASK); // RULE17
    end
    if (wr_srclr) begin
      next_sr = next_sr & ~(pwdata_i[15:0] & SR_MASK); // RULE19
    end
    // PC and SP loads only while stopped, so a running program is never torn
    if (wr_pc && can_load) begin
      next_pc = pwdata_i[15:0];
    end
    if (wr_sp && can_load) begin
      next_sp = pwdata_i[15:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= S_IDLE;
      pc    <= RESET_PC;
      sp    <= RESET_SP;
      sr    <= RESET_SR;
      insn  <= 16'h0000;
      opnd  <= 16'h0000;
      ea    <= 16'h0000;
      mem   <= '0;
    end else begin
      state <= next_state;
      pc    <= next_pc;
      sp    <= next_sp;
      sr    <= next_sr;
      insn  <= next_insn;
      opnd  <= next_opnd;
      ea    <= next_ea;
      mem   <= next_mem;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready  <= 1'h0;
      prdata  <= 32'h00000000;
      pslverr <= 1'h0;
      run     <= 1'h0;
      unsup   <= 1'h0;
    end else begin
      pready  <= apb_setup;
      prdata  <= apb_setup ? rd_val : 32'h00000000;
      pslverr <= apb_setup && !rd_hit;
      run     <= next_run;
      unsup   <= next_unsup;
    end
  end

  assign prdata_o     = prdata;
  assign pready_o     = pready;
  assign pslverr_o    = pslverr;
  assign mem_o        = mem;
  assign cpu_halted_o = sr[SR_HALT]; // RULE18
  assign osc_off_o    = sr[SR_NO_OSC]; // RULE17
  assign irq_en_o     = sr[SR_IRQ_EN]; // RULE19

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  property p_jump_target;
    (state == S_DECODE && is_jump && jmp_take) |=> (pc == $past(pc) + $past(jmp_ofs)) && (state == S_IDLE);
  endproperty
  a_jump_target: assert property (p_jump_target) else $error("taken jump target wrong"); // RULE8

  property p_jump_ofs;
    (state == S_DECODE && is_jump) |-> (jmp_ofs[0] == 1'h0) && (jmp_ofs[15:10] == {6{insn[9]}});
  endproperty
  a_jump_ofs: assert property (p_jump_ofs) else $error("jump offset not signed and doubled"); // RULE7

  property p_jump_flags;
    (state == S_DECODE && is_jump && !sr_sw) |=> (sr == $past(sr)) ##1 (state != S_DECODE || sr == $past(sr, 2));
  endproperty
  a_jump_flags: assert property (p_jump_flags) else $error("jump changed status"); // RULE9

  property p_jump_eq;
    (state == S_DECODE && is_jump && (cc == CC_EQ || cc == CC_NE)) |-> (jmp_take == (sr[SR_Z] == insn[10]));
  endproperty
  a_jump_eq: assert property (p_jump_eq) else $error("zero-flag jump condition wrong"); // RULE10

  property p_jump_signed;
    (state == S_DECODE && is_jump && cc == CC_GE) |-> (jmp_take != (sr[SR_N] ^ sr[SR_V]));
  endproperty
  a_jump_signed: assert property (p_jump_signed) else $error("signed jump condition wrong"); // RULE13

  property p_jump_always;
    (state == S_DECODE && is_jump && cc == CC_ALWAYS) |=> (pc == $past(pc) + $past(jmp_ofs));
  endproperty
  a_jump_always: assert property (p_jump_always) else $error("unconditional jump not taken"); // RULE14

  property p_push;
    (state == S_EXEC && op == OP_PUSH && !sr_sw) |=>
      (sp == $past(sp) - STEP_WORD) && mem.req && mem.we && (mem.addr == sp) && (mem.wdata == $past(opnd)) &&
      (sr == $past(sr));
  endproperty
  a_push: assert property (p_push) else $error("push stack write wrong"); // RULE2

  property p_call;
    (state == S_EXEC && op == OP_CALL) ##1 (mem_done [*1]) |=> (pc == $past(opnd, 2)) && (state == S_IDLE);
  endproperty
  a_call: assert property (p_call) else $error("call did not load target"); // RULE4

  property p_interrupt_return;
    (state == S_INTERRUPT_RETURN_SR && mem_done && !sr_sw) |=>
      (sr == ($past(mem_rdata_i) & SR_MASK)) && (sp == $past(sp) + STEP_WORD) && (mem.addr == sp);
  endproperty
  a_interrupt_return: assert property (p_interrupt_return) else $error("interrupt return pop wrong"); // RULE5

  property p_halt;
    (state == S_IDLE && sr[SR_HALT] && !sr_sw) |=> (state == S_IDLE) && !mem.req;
  endproperty
  a_halt: assert property (p_halt) else $error("halted core fetched"); // RULE18

  property p_rra;
    (state == S_EXEC && op == OP_RRA && !bw && (am != AM_REG || rsel > REG_SR) && !sr_sw) |=>
      (sr[SR_C] == $past(opnd[0])) && !sr[SR_V] && (sr[SR_N] == $past(opnd[15]));
  endproperty
  a_rra: assert property (p_rra) else $error("arithmetic shift flags wrong"); // RULE1

  property p_sign_ext;
    (state == S_EXEC && op == OP_SEXT) |-> (alu.value[15:8] == {8{opnd[7]}}) && !alu.v && (alu.z == !alu.c);
  endproperty
  a_sign_ext: assert property (p_sign_ext) else $error("sign extension wrong"); // RULE3

  property p_byte_swap;
    (state == S_EXEC && op == OP_BSWAP && !sr_sw) |=> (sr == $past(sr));
  endproperty
  a_byte_swap: assert property (p_byte_swap) else $error("byte swap changed status"); // RULE20

  property p_osc_off;
    (wr_srset && pwdata_i[15:0] == 16'h0028) |=> osc_off_o && irq_en_o;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("mask 28h did not stop oscillator"); // RULE17
endmodule

/* File: soje_mem_model.sv */
// Word memory on the core bus with optional wait states
`timescale 1ns/1ps
module soje_mem_model (
  input  wire logic                clk_sys_i,
  input  wire soje_pkg::soje_mem_t mem_i,
  input  wire logic                slow_i,
  output logic                     ack_o,
  output logic [15:0]              rdata_o
);
  import soje_pkg::*;
  logic [15:0] m [1024];
  logic        cnt = 1'b0;
  wire  [9:0]  idx = mem_i.addr[10:1];
  // Jump-to-self everywhere, so any stray target parks the core
  initial foreach (m[i]) m[i] = 16'h3FFF;
  // Slow mode accepts every other cycle, so the core must hold its request
  assign ack_o   = mem_i.req & (~slow_i | cnt);
  // Outside an accepted read the lines toggle rather than keep old data
  assign rdata_o = (ack_o & ~mem_i.we) ? m[idx] : {16{cnt}};
  always @(posedge clk_sys_i) begin
    cnt <= ~cnt;
    if (ack_o & mem_i.we & mem_i.be[0]) m[idx][7:0] <= mem_i.wdata[7:0];
    if (ack_o & mem_i.we & mem_i.be[1]) m[idx][15:8] <= mem_i.wdata[15:8];
  end
endmodule

/* File: single_operand_and_jump_execution_tb.sv */
// Self-checking bench for the single-operand and jump execution core
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
  $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module single_operand_and_jump_execution_tb;
  import soje_pkg::*;
  logic         clk_sys_i = 1'b0;
  logic         nrst_i = 1'b0;
  logic [7:0]   paddr = 8'h00;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [31:0]  pwdata = 32'h0;
  logic         slow = 1'b0;
  logic [31:0]  prdata, r;
  logic         pready, pslverr, ack, halted, osc, ien, e;
  logic [15:0]  rdata, gpc, gsp, gsr, sr, insn, ext, opnd, res, esr, epc, top_of_stack;
  soje_mem_t    mem;
  int           fails = 0;
  int           check_count = 0;
  int           cyc = 0;
  logic [127:0] rows [17];
  logic [5:0]   masks [6] = '{6'h28, 6'h18, 6'h08, 6'h01, 6'h02, 6'h04};
  soje_core dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .mem_o(mem),
    .mem_ack_i(ack), .mem_rdata_i(rdata), .cpu_halted_o(halted), .osc_off_o(osc), .irq_en_o(ien));
  soje_mem_model mm (.clk_sys_i(clk_sys_i), .mem_i(mem), .slow_i(slow), .ack_o(ack), .rdata_o(rdata));
  always #50 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_i);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Loads PC, SP and SR, lets the core run, then parks it and reads state back
  task automatic run(input logic [15:0] s, input logic [15:0] p);
    apb(1'b1, A_PC, 32'h0100);
    apb(1'b1, A_SP, {16'h0, p});
    apb(1'b1, A_SR, {16'h0, s});
    apb(1'b1, A_CTRL, 32'h1);
    repeat (60) @(posedge clk_sys_i);
    apb(1'b1, A_CTRL, 32'h0);
    repeat (30) begin
      apb(1'b0, A_STAT, 32'h0);
      if (r[1] === 1'b1) break;
    end
    apb(1'b0, A_PC, 32'h0);
    gpc = r[15:0];
    apb(1'b0, A_SP, 32'h0);
    gsp = r[15:0];
    apb(1'b0, A_SR, 32'h0);
    gsr = r[15:0];
  endtask
  initial begin
    // sr, insn, ext, operand, result, sr out, pc out, word below stack top
    rows = '{128'h0001_1012_0200_0002_8001_0104_0104_3FFF, 128'h0100_1112_0200_8003_C001_0005_0104_3FFF,
      128'h0107_1092_0200_1234_3412_0107_0104_3FFF, 128'h0100_1192_0200_0080_FF80_0005_0104_3FFF,
      128'h0105_1192_0200_0000_0000_0002_0104_3FFF, 128'h0003_1212_0200_5A5A_5A5A_0003_0104_5A5A,
      128'h0004_12B0_0400_0000_0000_0004_0400_0104, 128'h0000_2004_3FFF_0000_0000_0000_010A_3FFF,
      128'h0000_2404_3FFF_0000_0000_0000_0102_3FFF, 128'h0002_25FF_3FFF_0000_0000_0002_0500_3FFF,
      128'h0001_2804_3FFF_0000_0000_0001_0102_3FFF, 128'h0001_2C04_3FFF_0000_0000_0001_010A_3FFF,
      128'h0000_3004_3FFF_0000_0000_0000_0102_3FFF, 128'h0104_3404_3FFF_0000_0000_0104_010A_3FFF,
      128'h0004_3804_3FFF_0000_0000_0004_010A_3FFF, 128'h0000_3E00_3FFF_0000_0000_0000_FD02_3FFF,
      128'h0000_4000_3FFF_0000_0000_0000_0102_3FFF};
    repeat (20) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    apb(1'b0, A_SR, 32'h0);
    `CHK({r, halted, osc, ien, mem.req}, 36'h0)
    apb(1'b0, 8'h20, 32'h0);
    `CHK(e, 1'b1)
    foreach (rows[i]) begin
      {sr, insn, ext, opnd, res, esr, epc, top_of_stack} = rows[i];
      slow <= i[0];
      mm.m[10'h080] = insn;
      mm.m[10'h081] = ext;
      mm.m[10'h100] = opnd;
      mm.m[10'h17F] = 16'h3FFF;
      run(sr, 16'h0300);
      `CHK(gpc, epc)
      `CHK(gsr, esr)
      `CHK(gsp, (top_of_stack === 16'h3FFF) ? 16'h0300 : 16'h02FE)
      `CHK(mm.m[10'h100], res)
      `CHK(mm.m[10'h17F], top_of_stack)
    end
    apb(1'b0, A_STAT, 32'h0);
    `CHK(r[2], 1'b1)
    apb(1'b1, A_STAT, 32'h4);
    apb(1'b0, A_STAT, 32'h0);
    `CHK(r[2], 1'b0)
    mm.m[10'h080] = 16'h1300;
    mm.m[10'h17E] = 16'h0105;
    mm.m[10'h17F] = 16'h0400;
    run(16'h0000, 16'h02FC);
    `CHK({gsr, gpc, gsp}, 48'h0105_0400_0300)
    foreach (masks[i]) begin
      apb(1'b1, A_SR, 32'h0100);
      apb(1'b1, A_SRSET, {26'h0, masks[i]});
      apb(1'b0, A_SR, 32'h0);
      `CHK(r, {23'h0, 9'h100 | masks[i]})
      `CHK({osc, halted, ien}, masks[i][5:3])
      apb(1'b1, A_SRCLR, {26'h0, masks[i]});
      apb(1'b0, A_SR, 32'h0);
      `CHK(r, 32'h0100)
    end
    // Reset while stopped, with halt, oscillator-off and interrupt-enable set, must clear every status output again
    apb(1'b1, A_SRSET, 32'h38);
    apb(1'b0, A_SR, 32'h0);
    `CHK({osc, halted, ien}, 3'h7)
    nrst_i <= 1'b0;
    @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    apb(1'b0, A_SR, 32'h0);
    `CHK({r, halted, osc, ien, mem.req}, 36'h0)
    end_of_test();
  end
endmodule
